// *** shared/ssm_pkg.sv ***
package ssm_pkg;
  // word offsets on the wishbone bus
  localparam logic [7:0] OFS_CTRL_ONE  = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO  = 8'h04;
  localparam logic [7:0] OFS_BAUD      = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h14;
  localparam logic [7:0] OFS_DATA      = 8'h18;
  localparam logic [7:0] OFS_FW_PINS   = 8'h1C;
  // control one fields
  localparam int BIT_WCOL   = 7;
  localparam int BIT_ENABLE = 5;
  localparam int BIT_CKP    = 4;
  // control two fields
  localparam int BIT_GENERAL_CALL_ENABLE   = 7;
  localparam int BIT_ACKNOWLEDGE_STATUS = 6;
  localparam int BIT_ACKNOWLEDGE_VALUE  = 5;
  localparam int BIT_ACKEN  = 4;
  localparam int BIT_RCEN   = 3;
  localparam int BIT_PEN    = 2;
  localparam int BIT_REPEAT_START_ENABLE   = 1;
  localparam int BIT_SEN    = 0;
  // interrupt status bits
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_GCALL  = 1;
  localparam int IRQ_START  = 2;
  localparam int IRQ_STOP   = 3;
  localparam int IRQ_W      = 4;
  // port_mode_field codes
  localparam logic [3:0] MODE_SPI_M4    = 4'h0;
  localparam logic [3:0] MODE_SPI_M16   = 4'h1;
  localparam logic [3:0] MODE_SPI_M64   = 4'h2;
  localparam logic [3:0] MODE_SPI_MTMR  = 4'h3;
  localparam logic [3:0] MODE_SPI_S_SS  = 4'h4;
  localparam logic [3:0] MODE_SPI_S     = 4'h5;
  localparam logic [3:0] MODE_I2C_S7    = 4'h6;
  localparam logic [3:0] MODE_I2C_S10   = 4'h7;
  localparam logic [3:0] MODE_I2C_M     = 4'h8;
  localparam logic [3:0] MODE_I2C_FW    = 4'hB;
  localparam logic [3:0] MODE_I2C_S7I   = 4'hE;
  localparam logic [3:0] MODE_I2C_S10I  = 4'hF;
  // reset values
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;
  localparam logic [7:0] RST_BAUD     = 8'h00;
  // spi half periods in clk_i cycles (fosc/4, /16, /64)
  localparam logic [5:0] SPI_HALF_4  = 6'h02;
  localparam logic [5:0] SPI_HALF_16 = 6'h08;
  localparam logic [5:0] SPI_HALF_64 = 6'h20;
  localparam logic [7:0] GCALL_ADDR  = 8'h00;
  typedef enum logic [1:0] {MST_IDLE, MST_START, MST_BIT, MST_STOP} ssm_mst_type;
endpackage

// *** logic/ssm_ctrl.sv ***
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/1ns
module ssm_ctrl
  import ssm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  input  wire logic        second_timer_tick_i,
  output logic             spi_sck_o,
  output logic             spi_sck_oe_o,
  output logic             slave_select_used_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o
);

  typedef struct packed {
    logic [7:0]  ctl1;
    logic [7:0]  ctl2;
    logic [7:0]  baud;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] ien;
    logic [7:0]  rx_byte;
    logic [1:0]  fw_pins;
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic        scl_f;
    logic        sda_f;
    logic [4:0]  spi_cnt;
    logic        sck;
    logic        sck_oe;
    logic        ss_used;
    ssm_mst_type mst;
    logic [7:0]  baud_cnt;
    logic [1:0]  phase;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic        tx_mode;
    logic        tx_go;
    logic [7:0]  slv_shift;
    logic [3:0]  slv_cnt;
    logic        slv_active;
    logic        scl_oe;
    logic        sda_oe;
    logic        ack;
    logic [31:0] dat;
    logic        irq;
  } ssm_state_type;

  ssm_state_type r;
  ssm_state_type next_r;

  logic       bus_req;
  logic       wr;
  logic       rd;
  logic [3:0] mode;
  logic       tick;
  logic       dbit;
  logic       scl_rise;
  logic       sda_fall;
  logic       sda_rise;
  logic [IRQ_W-1:0] ev;

  function automatic logic is_i2c_slave(input logic [3:0] m);
    return (m == MODE_I2C_S7) || (m == MODE_I2C_S10) || (m == MODE_I2C_S7I) || (m == MODE_I2C_S10I);
  endfunction

  function automatic logic settled_edge(input logic [2:0] s, input logic f, input logic lvl);
    return (s[1] == s[2]) && (s[2] == lvl) && (f != lvl);
  endfunction

  always_comb
  begin
    next_r   = r;
    bus_req  = wb_cyc_i && wb_stb_i && !r.ack;
    wr       = bus_req && wb_we_i && wb_sel_i[0];
    rd       = bus_req && !wb_we_i;
    mode     = r.ctl1[3:0];
    tick     = 1'b0;
    dbit     = 1'b1;
    ev       = '0;
    next_r.ack = bus_req;
    // pins pass three stages; a level counts once stages two and three agree
    next_r.scl_s = {r.scl_s[1:0], scl_i};
    next_r.sda_s = {r.sda_s[1:0], sda_i};
    scl_rise = settled_edge(r.scl_s, r.scl_f, 1'b1);
    sda_rise = settled_edge(r.sda_s, r.sda_f, 1'b1);
    sda_fall = settled_edge(r.sda_s, r.sda_f, 1'b0);
    if (r.scl_s[1] == r.scl_s[2])
    begin
      next_r.scl_f = r.scl_s[2];
    end
    if (r.sda_s[1] == r.sda_s[2])
    begin
      next_r.sda_f = r.sda_s[2];
    end

    // register reads, unmapped words read zero
    if (rd)
    begin
      case (wb_adr_i & 8'hFC)
        OFS_CTRL_ONE: next_r.dat = {24'h000000, r.ctl1};
        OFS_CTRL_TWO: next_r.dat = {24'h000000, r.ctl2};
        OFS_BAUD:     next_r.dat = {24'h000000, r.baud};
        OFS_IRQ_STAT: next_r.dat = {28'h0000000, r.istat};
        OFS_IRQ_EN:   next_r.dat = {28'h0000000, r.ien};
        OFS_DATA:     next_r.dat = {24'h000000, r.rx_byte};
        OFS_FW_PINS:  next_r.dat = {30'h00000000, r.fw_pins};
        default:      next_r.dat = 32'h00000000;
      endcase
    end
    if (wr)
    begin
      case (wb_adr_i & 8'hFC)
        OFS_CTRL_ONE: next_r.ctl1 = wb_dat_i[7:0];
        OFS_CTRL_TWO: next_r.ctl2 = {wb_dat_i[7], r.ctl2[BIT_ACKNOWLEDGE_STATUS], wb_dat_i[5:0]};
        OFS_BAUD:     next_r.baud = wb_dat_i[7:0];
        OFS_IRQ_EN:   next_r.ien = wb_dat_i[IRQ_W-1:0];
        OFS_IRQ_CLR:  next_r.istat = r.istat & ~wb_dat_i[IRQ_W-1:0];
        OFS_FW_PINS:  next_r.fw_pins = wb_dat_i[1:0];
        OFS_DATA:
        begin
          // a write while a transfer runs is dropped and flagged
          if (r.mst != MST_IDLE || r.tx_go)
          begin
            next_r.ctl1[BIT_WCOL] = 1'b1;
          end
          else
          begin
            next_r.shift = wb_dat_i[7:0];
            next_r.tx_go = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // spi clock generator and slave select use flag; the shifter lives elsewhere
    next_r.sck_oe  = 1'b0;
    next_r.ss_used = 1'b0;
    if (!r.ctl1[BIT_ENABLE])
    begin
      next_r.sck     = r.ctl1[BIT_CKP];
      next_r.spi_cnt = 5'h00;
    end
    else
    begin
      case (mode)
        MODE_SPI_M4, MODE_SPI_M16, MODE_SPI_M64:
        begin
          next_r.sck_oe  = 1'b1;
          next_r.spi_cnt = r.spi_cnt + 5'h01;
          // fosc/4, fosc/16 and fosc/64 half periods
          // half periods need six bits, the counter only reaches 31
          if ((mode == MODE_SPI_M4 && {1'b0, r.spi_cnt} == SPI_HALF_4 - 6'h01) ||
              (mode == MODE_SPI_M16 && {1'b0, r.spi_cnt} == SPI_HALF_16 - 6'h01) ||
              (mode == MODE_SPI_M64 && {1'b0, r.spi_cnt} == SPI_HALF_64 - 6'h01))
          begin
            next_r.sck     = !r.sck;
            next_r.spi_cnt = 5'h00;
          end
        end
        MODE_SPI_MTMR:
        begin
          next_r.sck_oe = 1'b1;
          if (second_timer_tick_i)
          begin
            next_r.sck = !r.sck;
          end
        end
        MODE_SPI_S_SS: next_r.ss_used = 1'b1;
        default:       next_r.sck = r.ctl1[BIT_CKP];
      endcase
    end

    // i2c slave: start, stop and general call detection
    if (r.ctl1[BIT_ENABLE] && is_i2c_slave(mode))
    begin
      if (r.scl_f && sda_fall)
      begin
        next_r.slv_active = 1'b1;
        next_r.slv_cnt    = 4'h0;
        ev[IRQ_START]     = mode[3];
      end
      else if (r.scl_f && sda_rise)
      begin
        next_r.slv_active = 1'b0;
        ev[IRQ_STOP]      = mode[3];
      end
      else if (scl_rise && r.slv_active)
      begin
        next_r.slv_shift = {r.slv_shift[6:0], r.sda_f};
        next_r.slv_cnt   = r.slv_cnt + 4'h1;
        if (r.slv_cnt == 4'h7)
        begin
          // only the address byte is inspected
          next_r.slv_active = 1'b0;
          ev[IRQ_GCALL] = r.ctl2[BIT_GENERAL_CALL_ENABLE] && ({r.slv_shift[6:0], r.sda_f} == GCALL_ADDR);
        end
      end
    end
    else
    begin
      next_r.slv_active = 1'b0;
    end

    // i2c master engine, four baud phases per bit, no clock stretching
    if (r.mst == MST_IDLE)
    begin
      next_r.baud_cnt = r.baud;
      next_r.phase    = 2'h0;
    end
    else if (r.baud_cnt == 8'h00)
    begin
      tick            = 1'b1;
      next_r.baud_cnt = r.baud;
      next_r.phase    = r.phase + 2'h1;
    end
    else
    begin
      next_r.baud_cnt = r.baud_cnt - 8'h01;
    end
    if (r.bit_cnt == 4'h8)
    begin
      dbit = r.tx_mode || r.ctl2[BIT_ACKNOWLEDGE_VALUE];
    end
    else
    begin
      dbit = !r.tx_mode || r.shift[7];
    end

    case (r.mst)
      MST_IDLE:
      begin
        if (mode == MODE_I2C_FW && r.ctl1[BIT_ENABLE])
        begin
          next_r.scl_oe = r.fw_pins[0];
          next_r.sda_oe = r.fw_pins[1];
        end
        else if (mode != MODE_I2C_M || !r.ctl1[BIT_ENABLE])
        begin
          next_r.scl_oe = 1'b0;
          next_r.sda_oe = 1'b0;
          next_r.tx_go  = 1'b0;
        end
        else if (r.ctl2[BIT_SEN] || r.ctl2[BIT_REPEAT_START_ENABLE])
        begin
          next_r.mst = MST_START;
        end
        else if (r.ctl2[BIT_PEN])
        begin
          next_r.mst = MST_STOP;
        end
        else if (r.ctl2[BIT_RCEN] || r.ctl2[BIT_ACKEN] || r.tx_go)
        begin
          next_r.mst     = MST_BIT;
          next_r.tx_mode = r.tx_go && !r.ctl2[BIT_RCEN] && !r.ctl2[BIT_ACKEN];
          next_r.bit_cnt = (!r.ctl2[BIT_RCEN] && r.ctl2[BIT_ACKEN]) ? 4'h8 : 4'h0;
        end
      end
      MST_START:
      begin
        if (tick)
        begin
          case (r.phase)
            // restart begins with clock low, data released
            2'h0:
            begin
              next_r.scl_oe = r.ctl2[BIT_REPEAT_START_ENABLE];
              next_r.sda_oe = 1'b0;
            end
            2'h1: next_r.scl_oe = 1'b0;
            2'h2: next_r.sda_oe = 1'b1;
            default:
            begin
              next_r.scl_oe         = 1'b1;
              next_r.ctl2[BIT_SEN]  = 1'b0;
              next_r.ctl2[BIT_REPEAT_START_ENABLE] = 1'b0;
              next_r.mst            = MST_IDLE;
              ev[IRQ_DONE]          = 1'b1;
            end
          endcase
        end
      end
      MST_BIT:
      begin
        if (tick)
        begin
          case (r.phase)
            2'h0:
            begin
              next_r.scl_oe = 1'b1;
              next_r.sda_oe = !dbit;
            end
            2'h1: next_r.scl_oe = 1'b1;
            2'h2: next_r.scl_oe = 1'b0;
            default:
            begin
              next_r.scl_oe  = 1'b1;
              next_r.bit_cnt = r.bit_cnt + 4'h1;
              if (r.bit_cnt != 4'h8)
              begin
                next_r.shift = {r.shift[6:0], r.sda_f};
              end
              if (r.bit_cnt == 4'h8 || (!r.tx_mode && r.bit_cnt == 4'h7))
              begin
                next_r.mst    = MST_IDLE;
                next_r.sda_oe = 1'b0;
                ev[IRQ_DONE]  = 1'b1;
                // high means the slave did not acknowledge
                if (r.tx_mode)
                begin
                  next_r.ctl2[BIT_ACKNOWLEDGE_STATUS] = r.sda_f;
                  next_r.tx_go             = 1'b0;
                end
                else if (r.bit_cnt == 4'h7)
                begin
                  next_r.rx_byte        = {r.shift[6:0], r.sda_f};
                  next_r.ctl2[BIT_RCEN] = 1'b0;
                end
                else
                begin
                  next_r.ctl2[BIT_ACKEN] = 1'b0;
                end
              end
            end
          endcase
        end
      end
      MST_STOP:
      begin
        if (tick)
        begin
          case (r.phase)
            2'h0:
            begin
              next_r.scl_oe = 1'b1;
              next_r.sda_oe = 1'b1;
            end
            2'h1: next_r.scl_oe = 1'b0;
            2'h2: next_r.scl_oe = 1'b0;
            default:
            begin
              next_r.sda_oe        = 1'b0;
              next_r.ctl2[BIT_PEN] = 1'b0;
              next_r.mst           = MST_IDLE;
              ev[IRQ_DONE]         = 1'b1;
            end
          endcase
        end
      end
      default: next_r.mst = MST_IDLE;
    endcase

    // set after clear so a same-cycle event survives
    next_r.istat = next_r.istat | ev;
    next_r.irq   = |(next_r.istat & next_r.ien);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r       <= '0;
      r.ctl1  <= RST_CTRL_ONE;
      r.ctl2  <= RST_CTRL_TWO;
      r.baud  <= RST_BAUD;
      r.scl_s <= 3'h7;
      r.sda_s <= 3'h7;
      r.scl_f <= 1'b1;
      r.sda_f <= 1'b1;
      r.mst   <= MST_IDLE;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign wb_dat_o            = r.dat;
  assign wb_ack_o            = r.ack;
  assign irq_o               = r.irq;
  assign spi_sck_o           = r.sck;
  assign spi_sck_oe_o        = r.sck_oe;
  assign slave_select_used_o = r.ss_used;
  // open drain: low when enabled, never driven high
  assign scl_o               = 1'b0;
  assign sda_o               = 1'b0;
  assign scl_oe_o            = r.scl_oe;
  assign sda_oe_o            = r.sda_oe;

endmodule

// *** test/ssm_ctrl_chk.sv ***
`timescale 1ns/1ns
module ssm_ctrl_chk
  import ssm_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_ack_o,
  input wire logic        irq_o,
  input wire logic        second_timer_tick_i,
  input wire logic        spi_sck_o,
  input wire logic        spi_sck_oe_o,
  input wire logic        slave_select_used_o,
  input wire logic        scl_oe_o,
  input wire logic        sda_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [5:0] mir;
  logic [1:0] fw;
  logic [7:0] cnt;
  logic [7:0] age;
  wire        wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & wb_sel_i[0];
  // mirror of control one, taken on the same edge as the design
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mir <= 6'h00;
      fw  <= 2'h0;
      cnt <= 8'h00;
      age <= 8'h00;
    end
    else
    begin
      if (wr && wb_adr_i[7:2] == OFS_CTRL_ONE[7:2])
        mir <= wb_dat_i[5:0];
      if (wr && wb_adr_i[7:2] == OFS_FW_PINS[7:2])
        fw <= wb_dat_i[1:0];
      cnt <= $changed(spi_sck_o) ? 8'h00 : cnt + {7'h00, cnt != 8'hFF};
      age <= $changed(mir) ? 8'h00 : age + {7'h00, age != 8'hFF};
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack;
    s_req |=> s_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a one cycle answer");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_oe_master;
    spi_sck_oe_o == $past(mir[5] && mir[3:2] == 2'b00);
  endproperty
  a_oe_master: assert property (p_oe_master) else $error("sck enable wrong");
  property p_m64;
    mir == 6'h22 && age > 8'd70 && $changed(spi_sck_o) |-> cnt == 8'd31;
  endproperty
  a_m64: assert property (p_m64) else $error("slow spi half period wrong");
  property p_tmr;
    mir == 6'h23 && age > 8'd4 && $changed(spi_sck_o) |-> $past(second_timer_tick_i);
  endproperty
  a_tmr: assert property (p_tmr) else $error("sck moved without timer tick");
  property p_fw;
    mir == 6'h2B && age > 8'd2 |-> scl_oe_o == $past(fw[0]) && sda_oe_o == $past(fw[1]);
  endproperty
  a_fw: assert property (p_fw) else $error("firmware pins not followed");
  property p_res;
    (mir == 6'h2C || mir == 6'h2D) && age > 8'd2 |-> !scl_oe_o && !sda_oe_o && !spi_sck_oe_o;
  endproperty
  a_res: assert property (p_res) else $error("reserved mode drives a pin");
  property p_ss;
    slave_select_used_o == $past(mir[5] && mir[3:0] == 4'h4);
  endproperty
  a_ss: assert property (p_ss) else $error("select use wrong");
  property p_irq_off;
    wr && wb_adr_i[7:2] == OFS_IRQ_EN[7:2] && wb_dat_i[3:0] == 4'h0 |-> ##2 !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq high with nothing enabled");
endmodule
bind ssm_ctrl ssm_ctrl_chk chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
  .wb_sel_i, .wb_ack_o, .irq_o, .second_timer_tick_i, .spi_sck_o, .spi_sck_oe_o, .slave_select_used_o,
  .scl_oe_o, .sda_oe_o);

// *** test/ssm_peer.sv ***
`timescale 1ns/1ns
module ssm_peer
(
  input  wire logic clk_i,
  input  wire logic scl_oe_i,
  input  wire logic sda_oe_i,
  input  wire logic nack_i,
  output logic      scl_o,
  output logic      sda_o,
  output int        starts_o
);
  logic ack_pull = 1'b0;
  logic m_scl    = 1'b0;
  logic m_sda    = 1'b0;
  logic sda_q    = 1'b1;
  logic scl_q    = 1'b1;
  int   bits     = 0;
  int   starts   = 0;
  // pull-ups: a released line goes high
  assign scl_o = !(scl_oe_i | m_scl);
  assign sda_o = !(sda_oe_i | m_sda | ack_pull);
  assign starts_o = starts;
  always @(posedge clk_i)
  begin
    scl_q <= scl_o;
    sda_q <= sda_o;
    if (scl_o && sda_q && !sda_o)
    begin
      bits   <= 0;
      starts <= starts + 1;
    end
    else if (!scl_q && scl_o)
      bits <= bits + 1;
    else if (scl_q && !scl_o)
    begin
      ack_pull <= bits == 8 && !nack_i;
      if (bits == 9)
        bits <= 0;
    end
  end
  // slow general call as a master, 8 cycles a level for the input filter
  task automatic gcall();
    m_sda <= 1'b1;
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 10; i++)
    begin
      m_scl <= 1'b1;
      repeat (4) @(posedge clk_i);
      // data moves only while the clock is low
      m_sda <= i < 8 || i == 9;
      repeat (4) @(posedge clk_i);
      m_scl <= i == 9;
      repeat (8) @(posedge clk_i);
    end
    m_scl <= 1'b0;
    repeat (8) @(posedge clk_i);
    m_sda <= 1'b0;
  endtask
endmodule

// *** test/test_ssm_ctrl.sv ***
`timescale 1ns/1ns
module test_ssm_ctrl
  import ssm_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] dat   = 32'h0;
  logic [3:0]  sel   = 4'h0;
  logic        tick  = 1'b0;
  logic        nack  = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, irq_o, spi_sck_o, spi_sck_oe_o, ss_used, scl_oe_o, sda_oe_o, scl, sda;
  logic [31:0] rd;
  int          err_count = 0;
  int          samples_checked = 0;
  int          tcnt = 0;
  int          n, c, s0;
  always #10 clk_i = ~clk_i;
  // timer tick every 5 cycles
  always @(posedge clk_i)
  begin
    tcnt <= tcnt == 4 ? 0 : tcnt + 1;
    tick <= tcnt == 4;
  end
  ssm_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .second_timer_tick_i(tick), .spi_sck_o(spi_sck_o), .spi_sck_oe_o(spi_sck_oe_o),
    .slave_select_used_o(ss_used), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe_o));
  ssm_peer peer_u (.clk_i(clk_i), .scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o), .nack_i(nack), .scl_o(scl),
    .sda_o(sda), .starts_o(s0));
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // request held until ack is sampled high at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1)
      err_count++;
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp("register read", e, rd);
  endtask
  task automatic wirq(input logic [31:0] m);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (irq_o !== 1'b1 && n < 3000);
    cmp("irq level", 32'h1, {31'h0, irq_o});
    rchk(OFS_IRQ_STAT, m);
    bus(1'b1, OFS_IRQ_CLR, m);
  endtask
  task automatic half(output int h);
    logic v;
    repeat (2)
    begin
      @(negedge clk_i);
      v = spi_sck_o;
      h = 1;
      while (spi_sck_o === v && h < 300)
      begin
        @(negedge clk_i);
        h++;
      end
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(OFS_CTRL_ONE, {24'h0, RST_CTRL_ONE});
    rchk(OFS_CTRL_TWO, {24'h0, RST_CTRL_TWO});
    rchk(8'h40, 32'h0);
    for (int m = 4; m < 6; m++)
    begin
      bus(1'b1, OFS_CTRL_ONE, 32'h20 + m);
      repeat (3) @(posedge clk_i);
      cmp("select used", {31'h0, m == 4}, {31'h0, ss_used});
    end
    for (int m = 12; m < 14; m++)
    begin
      bus(1'b1, OFS_CTRL_ONE, 32'h20 + m);
      repeat (3) @(posedge clk_i);
      cmp("pins released", 32'h0, {29'h0, scl_oe_o, sda_oe_o, spi_sck_oe_o});
    end
    for (int m = 0; m < 2; m++)
    begin
      bus(1'b1, OFS_CTRL_ONE, 32'h20 + m);
      half(c);
      cmp("fast half period", m == 0 ? 32'd2 : 32'd8, c);
    end
    bus(1'b1, OFS_CTRL_ONE, 32'h22);
    repeat (80) @(posedge clk_i);
    half(c);
    cmp("slow half period", 32'd32, c);
    cmp("sck driven", 32'h1, {31'h0, spi_sck_oe_o});
    bus(1'b1, OFS_CTRL_ONE, 32'h23);
    half(c);
    cmp("timer half period", 32'd5, c);
    bus(1'b1, OFS_CTRL_ONE, 32'h2B);
    for (int p = 1; p < 3; p++)
    begin
      bus(1'b1, OFS_FW_PINS, p);
      repeat (3) @(posedge clk_i);
      cmp("firmware pins", p, {30'h0, sda_oe_o, scl_oe_o});
    end
    bus(1'b1, OFS_FW_PINS, 32'h0);
    bus(1'b1, OFS_CTRL_ONE, 32'h28);
    bus(1'b1, OFS_BAUD, 32'h3);
    bus(1'b1, OFS_IRQ_EN, 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      nack <= k[0];
      bus(1'b1, OFS_CTRL_TWO, 32'h1 << BIT_SEN);
      wirq(32'h1);
      bus(1'b1, OFS_DATA, 32'hA5);
      wirq(32'h1);
      rchk(OFS_CTRL_TWO, k << BIT_ACKNOWLEDGE_STATUS);
      c = s0;
      bus(1'b1, OFS_CTRL_TWO, 32'h1 << BIT_REPEAT_START_ENABLE);
      wirq(32'h1);
      bus(1'b0, OFS_CTRL_TWO, 32'h0);
      cmp("restart bit", 32'h0, {31'h0, rd[BIT_REPEAT_START_ENABLE]});
      cmp("restarts on wire", c + 1, s0);
      bus(1'b1, OFS_CTRL_TWO, 32'h1 << BIT_PEN);
      wirq(32'h1);
    end
    bus(1'b1, OFS_CTRL_ONE, 32'h26);
    bus(1'b1, OFS_CTRL_TWO, 32'h1 << BIT_GENERAL_CALL_ENABLE);
    bus(1'b1, OFS_IRQ_EN, 32'h1 << IRQ_GCALL);
    peer_u.gcall();
    wirq(32'h1 << IRQ_GCALL);
    // start and stop events only in the interrupting slave modes
    bus(1'b1, OFS_CTRL_ONE, 32'h2E);
    peer_u.gcall();
    repeat (8) @(posedge clk_i);
    rchk(OFS_IRQ_STAT, (32'h1 << IRQ_GCALL) | (32'h1 << IRQ_START) | (32'h1 << IRQ_STOP));
    // status still set, so dropping the enable must drop the line
    bus(1'b1, OFS_IRQ_EN, 32'h0);
    repeat (3) @(posedge clk_i);
    cmp("irq level", 32'h0, {31'h0, irq_o});
    results();
  end
  // whole run is well under this many cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    results();
  end
endmodule
